// [src/serial_program_entry_defs.vh]
// constants for the serial programming entry block
`ifndef SERIAL_PROGRAM_ENTRY_DEFS_VH
`define SERIAL_PROGRAM_ENTRY_DEFS_VH
`define KEY_WIDTH        32
`define KEY_VALUE        32'h5a3c_9e61
`define KEY_COUNT_WIDTH  6
`define CMD_WIDTH        6
`define ADDR_WIDTH       16
`define WORD_WIDTH       14
`define ST_IDLE          3'h0
`define ST_KEY           3'h1
`define ST_SESSION       3'h2
`define CMD_LOAD_ADDR    6'h01
`define CMD_WRITE_WORD   6'h02
`define CMD_READ_WORD    6'h04
`define CMD_INC_ADDR     6'h06
`define SPACE_PROGRAM    2'h0
`define SPACE_EEPROM     2'h1
`define SPACE_USER_ID    2'h2
`define SPACE_CONFIG     2'h3
`define ADDR_EEPROM_BASE 16'hf000
`define ADDR_USER_ID     16'h8000
`define ADDR_CONFIG      16'h8007
`define LV_ENTRY_BIT     13
`endif

// [src/pin_sync.v]
// two flip-flop synchroniser for one pin level
`timescale 1ns/100ps
module pin_sync (
   input  wire ref_clk_in,
   input  wire rst_n_in,
   input  wire pin_in,
   output wire level_out
);
   reg stage_a;
   reg stage_b;
   always @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         stage_a <= 1'b0;
         stage_b <= 1'b0;
      end else begin
         stage_a <= pin_in;
         stage_b <= stage_a;
      end
   end
   assign level_out = stage_b;
endmodule

// [src/serial_program_entry.v]
// serial programming entry, session control and word transfer
`timescale 1ns/100ps
`include "serial_program_entry_defs.vh"
// Behaviour
// - clock, data low plus high voltage enters
// - key entry accepted only when enable bit set
// - enable bit cleared only in high-voltage session
// - key session lasts while master clear low
// - enable bit set forces master clear reset
// - clock is input, data is bidirectional
// - session writes program, eeprom, ids, config
module serial_program_entry (
   input  wire                     ref_clk_in,
   input  wire                     resetn_in,
   input  wire                     prog_clock_pin_in,
   input  wire                     prog_data_pin_in,
   output reg                      prog_data_pin_out,
   output reg                      prog_data_pin_oe_out,
   input  wire                     master_clear_pin_in,
   input  wire                     high_entry_voltage_in,
   input  wire                     low_voltage_entry_enable_in,
   input  wire                     mclr_reset_config_in,
   output wire                     mclr_reset_enable_out,
   output wire                     device_reset_out,
   output reg                      session_active_out,
   output reg                      session_high_voltage_out,
   output reg                      mem_write_out,
   output reg  [1:0]               mem_space_out,
   output reg  [`ADDR_WIDTH-1:0]   mem_addr_out,
   output reg  [`WORD_WIDTH-1:0]   mem_wdata_out,
   output reg                      mem_read_out,
   input  wire [`WORD_WIDTH-1:0]   mem_rdata_in
);
   reg  rst_a;
   reg  rst_n;
   always @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         rst_a <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_a <= 1'b1;
         rst_n <= rst_a;
      end
   end

   wire clk_s;
   wire dat_s;
   wire mclr_s;
   wire hv_s;
   // pins come from the programmer's domain
   pin_sync u_sync_clk  (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n), .pin_in(prog_clock_pin_in),
                         .level_out(clk_s));
   pin_sync u_sync_dat  (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n), .pin_in(prog_data_pin_in),
                         .level_out(dat_s));
   pin_sync u_sync_mclr (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n), .pin_in(master_clear_pin_in),
                         .level_out(mclr_s));
   pin_sync u_sync_hv   (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n), .pin_in(high_entry_voltage_in),
                         .level_out(hv_s));

   reg  clk_d;
   always @(posedge ref_clk_in or negedge rst_n) begin
      if (!rst_n)
         clk_d <= 1'b0;
      else
         clk_d <= clk_s;
   end
   wire clk_rise = clk_s & ~clk_d;
   wire clk_fall = ~clk_s & clk_d;

   // live enable bit: the stored fuse, cleared by a high-voltage config write
   reg  lv_cleared;
   wire lv_enable = low_voltage_entry_enable_in & ~lv_cleared;
   assign mclr_reset_enable_out = lv_enable | mclr_reset_config_in;
   assign device_reset_out = (mclr_reset_enable_out & ~mclr_s) | session_active_out;

   function [1:0] space_of;
      input [`ADDR_WIDTH-1:0] a;
      begin
         if (a >= `ADDR_EEPROM_BASE)
            space_of = `SPACE_EEPROM;
         else if (a == `ADDR_CONFIG || a == `ADDR_CONFIG + 16'h0001)
            space_of = `SPACE_CONFIG;
         else if (a >= `ADDR_USER_ID && a < `ADDR_CONFIG)
            space_of = `SPACE_USER_ID;
         else
            space_of = `SPACE_PROGRAM;
      end
   endfunction

   reg  [2:0]                  state;
   reg  [`KEY_WIDTH-1:0]       shift;
   reg  [`KEY_COUNT_WIDTH-1:0] bit_cnt;
   reg  [`CMD_WIDTH-1:0]       cmd;
   reg                         in_payload;
   reg  [`WORD_WIDTH-1:0]      out_word;
   reg                         mclr_d;
   wire [`KEY_WIDTH-1:0]       shifted = {shift[`KEY_WIDTH-2:0], dat_s};

   always @(posedge ref_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         state                    <= `ST_IDLE;
         shift                    <= 32'h0000_0000;
         bit_cnt                  <= 6'h00;
         cmd                      <= 6'h00;
         in_payload               <= 1'b0;
         out_word                 <= 14'h0000;
         mclr_d                   <= 1'b0;   // same level as the synchroniser in reset, so no false fall
         lv_cleared               <= 1'b0;
         session_active_out       <= 1'b0;
         session_high_voltage_out <= 1'b0;
         mem_write_out            <= 1'b0;
         mem_read_out             <= 1'b0;
         mem_space_out            <= 2'h0;
         mem_addr_out             <= 16'h0000;
         mem_wdata_out            <= 14'h0000;
         prog_data_pin_out        <= 1'b0;
         prog_data_pin_oe_out     <= 1'b0;
      end else begin
         mclr_d        <= mclr_s;
         mem_write_out <= 1'b0;
         mem_read_out  <= 1'b0;
         case (state)
            `ST_IDLE: begin
               bit_cnt <= 6'h00;
               shift   <= 32'h0000_0000;
               if (hv_s && !clk_s && !dat_s) begin
                  state                    <= `ST_SESSION;
                  session_active_out       <= 1'b1;
                  session_high_voltage_out <= 1'b1;
                  mem_addr_out             <= 16'h0000;
               end else if (lv_enable && !mclr_s && mclr_d) begin
                  state <= `ST_KEY;
               end
            end
            `ST_KEY: begin
               if (mclr_s || !lv_enable || hv_s) begin
                  state <= `ST_IDLE;
               end else if (clk_fall) begin
                  shift   <= shifted;
                  bit_cnt <= bit_cnt + 6'h01;
                  if (bit_cnt == `KEY_WIDTH - 1) begin
                     // a wrong key returns to idle; a fresh fall of master clear retries
                     if (shifted == `KEY_VALUE) begin
                        state                    <= `ST_SESSION;
                        session_active_out       <= 1'b1;
                        session_high_voltage_out <= 1'b0;
                        mem_addr_out             <= 16'h0000;
                     end else begin
                        state <= `ST_IDLE;
                     end
                     bit_cnt <= 6'h00;
                  end
               end
            end
            `ST_SESSION: begin
               if (session_high_voltage_out ? !hv_s : mclr_s) begin
                  state                    <= `ST_IDLE;
                  session_active_out       <= 1'b0;
                  session_high_voltage_out <= 1'b0;
                  prog_data_pin_oe_out     <= 1'b0;
                  in_payload               <= 1'b0;
                  bit_cnt                  <= 6'h00;
               end else if (!in_payload && clk_fall) begin
                  shift   <= shifted;
                  bit_cnt <= bit_cnt + 6'h01;
                  if (bit_cnt == `CMD_WIDTH - 1) begin
                     cmd     <= shifted[`CMD_WIDTH-1:0];
                     bit_cnt <= 6'h00;
                     case (shifted[`CMD_WIDTH-1:0])
                        `CMD_INC_ADDR:
                           mem_addr_out <= mem_addr_out + 16'h0001;
                        `CMD_LOAD_ADDR, `CMD_WRITE_WORD:
                           in_payload <= 1'b1;
                        `CMD_READ_WORD: begin
                           in_payload    <= 1'b1;
                           mem_read_out  <= 1'b1;
                           mem_space_out <= space_of(mem_addr_out);
                        end
                        default:
                           in_payload <= 1'b0;
                     endcase
                  end
               end else if (in_payload && cmd == `CMD_READ_WORD) begin
                  // device drives data on rising edges so the programmer samples on falling
                  if (bit_cnt == 6'h00 && !prog_data_pin_oe_out)
                     out_word <= mem_rdata_in;
                  if (clk_rise) begin
                     prog_data_pin_oe_out <= 1'b1;
                     prog_data_pin_out    <= out_word[0];
                     out_word             <= {1'b0, out_word[`WORD_WIDTH-1:1]};
                  end
                  if (clk_fall) begin
                     bit_cnt <= bit_cnt + 6'h01;
                     if (bit_cnt == `WORD_WIDTH - 1) begin
                        in_payload           <= 1'b0;
                        bit_cnt              <= 6'h00;
                        prog_data_pin_oe_out <= 1'b0;
                     end
                  end
               end else if (in_payload && clk_fall) begin
                  // payload arrives least significant bit first
                  shift   <= {dat_s, shift[`KEY_WIDTH-1:1]};
                  bit_cnt <= bit_cnt + 6'h01;
                  if (bit_cnt == 6'h0f) begin
                     in_payload <= 1'b0;
                     bit_cnt    <= 6'h00;
                     if (cmd == `CMD_LOAD_ADDR) begin
                        mem_addr_out <= {dat_s, shift[`KEY_WIDTH-1:`KEY_WIDTH-15]};
                     end else begin
                        mem_write_out <= 1'b1;
                        mem_space_out <= space_of(mem_addr_out);
                        mem_wdata_out <= shift[`KEY_WIDTH-2:`KEY_WIDTH-15];
                        if (space_of(mem_addr_out) == `SPACE_CONFIG && mem_addr_out == `ADDR_CONFIG &&
                            !shift[`KEY_WIDTH-15+`LV_ENTRY_BIT]) begin
                           if (session_high_voltage_out)
                              lv_cleared <= 1'b1;
                           else
                              mem_wdata_out[`LV_ENTRY_BIT] <= 1'b1;
                        end
                     end
                  end
               end
            end
            default:
               state <= `ST_IDLE;
         endcase
      end
   end
endmodule

// [tb/serial_program_entry_asserts.sv]
// checker for the serial programming entry block
`timescale 1ns/100ps
`include "serial_program_entry_defs.vh"
module serial_program_entry_asserts (
   input wire                   ref_clk_in,
   input wire                   resetn_in,
   input wire                   prog_clock_pin_in,
   input wire                   prog_data_pin_in,
   input wire                   master_clear_pin_in,
   input wire                   high_entry_voltage_in,
   input wire                   low_voltage_entry_enable_in,
   input wire                   mclr_reset_config_in,
   input wire                   mclr_reset_enable_out,
   input wire                   prog_data_pin_oe_out,
   input wire                   session_active_out,
   input wire                   session_high_voltage_out,
   input wire                   mem_write_out,
   input wire [1:0]             mem_space_out,
   input wire [`ADDR_WIDTH-1:0] mem_addr_out,
   input wire [`WORD_WIDTH-1:0] mem_wdata_out
);
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (!resetn_in);
   property p_reset_or; !low_voltage_entry_enable_in
      |-> mclr_reset_enable_out == mclr_reset_config_in; endproperty
   a_reset_or: assert property (p_reset_or) else $error("reset enable wrong");
   property p_key_reset; $rose(session_active_out) && !session_high_voltage_out
      |-> mclr_reset_enable_out; endproperty
   a_key_reset: assert property (p_key_reset) else $error("key session without master clear reset");
   property p_hv_enter; $rose(high_entry_voltage_in) && !prog_clock_pin_in && !prog_data_pin_in
      && !session_active_out |-> ##[1:6] (session_active_out && session_high_voltage_out); endproperty
   a_hv_enter: assert property (p_hv_enter) else $error("no high voltage entry");
   property p_entry_gate; $rose(session_active_out) |-> session_high_voltage_out || low_voltage_entry_enable_in;
   endproperty
   a_entry_gate: assert property (p_entry_gate) else $error("key entry while disabled");
   property p_hv_leave; session_high_voltage_out && !high_entry_voltage_in |-> ##[1:6] !session_active_out; endproperty
   a_hv_leave: assert property (p_hv_leave) else $error("session kept without voltage");
   property p_key_leave; session_active_out && !session_high_voltage_out && master_clear_pin_in
      |-> ##[1:6] !session_active_out; endproperty
   a_key_leave: assert property (p_key_leave) else $error("session kept after master clear");
   property p_key_mclr; $rose(session_active_out) && !session_high_voltage_out |-> !master_clear_pin_in; endproperty
   a_key_mclr: assert property (p_key_mclr) else $error("key session with master clear high");
   property p_oe_session; $rose(prog_data_pin_oe_out) |-> session_active_out; endproperty
   a_oe_session: assert property (p_oe_session) else $error("data driven outside session");
   property p_write_pulse; mem_write_out |-> session_active_out ##1 !mem_write_out; endproperty
   a_write_pulse: assert property (p_write_pulse) else $error("bad write pulse");
   property p_lv_keep; mem_write_out && mem_space_out == `SPACE_CONFIG && mem_addr_out == `ADDR_CONFIG
      && !session_high_voltage_out |-> mem_wdata_out[`LV_ENTRY_BIT]; endproperty
   a_lv_keep: assert property (p_lv_keep) else $error("enable bit cleared by key session");
endmodule
bind serial_program_entry serial_program_entry_asserts u_asserts (.*);

// [tb/programmer_model.sv]
// programmer model driving the serial programming pins
`timescale 1ns/100ps
module programmer_model (
   input  wire ref_clk_in,
   input  wire prog_data_in,
   output reg  prog_clock_out,
   output reg  prog_data_out,
   output reg  master_clear_out,
   output reg  high_voltage_out
);
   reg [31:0] rx;
   initial {prog_clock_out, prog_data_out, master_clear_out, high_voltage_out, rx} = {4'h2, 32'h0000_0000};
   // data moves with the clock rise so it is settled at the sampling fall
   task shift(input [31:0] v, input integer n, input msb);
      integer i;
      begin
         for (i = 0; i < n; i = i + 1) begin
            @(negedge ref_clk_in);
            prog_clock_out = 1'b1;
            prog_data_out = msb ? v[n-1-i] : v[i];
            repeat (4) @(negedge ref_clk_in);
            prog_clock_out = 1'b0;
            rx = {prog_data_in, rx[31:1]};
            repeat (3) @(negedge ref_clk_in);
         end
         prog_data_out = ~prog_data_out;
      end
   endtask
   task enter_key(input [31:0] key);
      begin
         master_clear_out = 1'b1;
         repeat (4) @(negedge ref_clk_in);
         master_clear_out = 1'b0;
         repeat (4) @(negedge ref_clk_in);
         shift(key, 32, 1'b1);
      end
   endtask
endmodule

// [tb/serial_program_entry_tb.sv]
// self-checking bench for the serial programming entry block
`timescale 1ns/100ps
`include "serial_program_entry_defs.vh"
module serial_program_entry_tb;
   reg         ref_clk_in = 1'b0;
   reg         resetn_in = 1'b0;
   reg         low_voltage_entry_enable_in = 1'b0;
   reg         mclr_reset_config_in = 1'b0;
   reg  [13:0] mem_rdata_in = 14'h2d3c;
   wire        prog_clock_pin_in, master_clear_pin_in, high_entry_voltage_in, prg_dat, mem_read_out;
   wire        prog_data_pin_out, prog_data_pin_oe_out, mclr_reset_enable_out, device_reset_out;
   wire        session_active_out, session_high_voltage_out, mem_write_out;
   wire [1:0]  mem_space_out;
   wire [15:0] mem_addr_out;
   wire [13:0] mem_wdata_out;
   wire        prog_data_pin_in = prog_data_pin_oe_out ? prog_data_pin_out : prg_dat;
   integer     errors = 0;
   integer     checked = 0;
   always #10 ref_clk_in = ~ref_clk_in;
   programmer_model prg (.ref_clk_in(ref_clk_in), .prog_data_in(prog_data_pin_in), .prog_clock_out(prog_clock_pin_in),
      .prog_data_out(prg_dat), .master_clear_out(master_clear_pin_in), .high_voltage_out(high_entry_voltage_in));
   serial_program_entry DUT (
      .ref_clk_in                  (ref_clk_in),
      .resetn_in                   (resetn_in),
      .prog_clock_pin_in           (prog_clock_pin_in),
      .prog_data_pin_in            (prog_data_pin_in),
      .prog_data_pin_out           (prog_data_pin_out),
      .prog_data_pin_oe_out        (prog_data_pin_oe_out),
      .master_clear_pin_in         (master_clear_pin_in),
      .high_entry_voltage_in       (high_entry_voltage_in),
      .low_voltage_entry_enable_in (low_voltage_entry_enable_in),
      .mclr_reset_config_in        (mclr_reset_config_in),
      .mclr_reset_enable_out       (mclr_reset_enable_out),
      .device_reset_out            (device_reset_out),
      .session_active_out          (session_active_out),
      .session_high_voltage_out    (session_high_voltage_out),
      .mem_write_out               (mem_write_out),
      .mem_space_out               (mem_space_out),
      .mem_addr_out                (mem_addr_out),
      .mem_wdata_out               (mem_wdata_out),
      .mem_read_out                (mem_read_out),
      .mem_rdata_in                (mem_rdata_in)
   );
   task check(input string what, input [15:0] seen, input [15:0] exp);
      begin
         checked = checked + 1;
         if (seen !== exp) begin
            errors = errors + 1;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
         end
      end
   endtask
   task test_done;
      begin
         $display("checks %0d mismatches %0d", checked, errors);
         if (errors == 0 && checked > 0)
            $display("verification passed");
         else
            $display("verification failed");
         $finish;
      end
   endtask
   // bounded wait on {write pulse, session}; a timeout ends the run
   task wait_for(input [1:0] mask, input [1:0] val);
      integer i;
      begin
         for (i = 0; i < 40 && ({mem_write_out, session_active_out} & mask) !== val; i = i + 1)
            @(negedge ref_clk_in);
         check("wait", {mem_write_out, session_active_out} & mask, val);
         if (i == 40)
            test_done;
      end
   endtask
   task word(input [5:0] cmd, input [15:0] payload);
      begin
         prg.shift({26'h000_0000, cmd}, 6, 1'b1);
         prg.shift({16'h0000, payload}, 16, 1'b0);
      end
   endtask
   task write(input [15:0] addr, input [13:0] data, input [1:0] space);
      begin
         word(`CMD_LOAD_ADDR, addr);
         word(`CMD_WRITE_WORD, {2'b00, data});
         wait_for(2'b10, 2'b10);
         check("space", mem_space_out, space);
         check("address", mem_addr_out, addr);
      end
   endtask
   task test_fuse;
      integer k;
      begin
         for (k = 0; k < 4; k = k + 1) begin
            {low_voltage_entry_enable_in, mclr_reset_config_in} = k[1:0];
            @(negedge ref_clk_in);
            check("reset enable", mclr_reset_enable_out, k != 0);
         end
         $display("fuse test done");
      end
   endtask
   task test_key;
      begin
         prg.enter_key(`KEY_VALUE ^ 32'h0000_0001);
         repeat (12) @(negedge ref_clk_in);
         check("bad key session", session_active_out, 1'b0);
         prg.enter_key(`KEY_VALUE);
         wait_for(2'b01, 2'b01);
         check("key hv flag", session_high_voltage_out, 1'b0);
         write(`ADDR_CONFIG, 14'h0123, `SPACE_CONFIG);
         check("key config word", mem_wdata_out, 14'h2123);
         prg.master_clear_out = 1'b1;
         wait_for(2'b01, 2'b00);
         low_voltage_entry_enable_in = 1'b0;
         prg.enter_key(`KEY_VALUE);
         repeat (12) @(negedge ref_clk_in);
         check("disabled key session", session_active_out, 1'b0);
         check("core reset", device_reset_out, 1'b1);
         prg.master_clear_out = 1'b1;
         $display("key test done");
      end
   endtask
   task test_hv;
      begin
         prg.prog_data_out = 1'b0;
         prg.high_voltage_out = 1'b1;
         wait_for(2'b01, 2'b01);
         check("hv flag", session_high_voltage_out, 1'b1);
         write(16'hf005, 14'h1abc, `SPACE_EEPROM);
         check("eeprom word", mem_wdata_out, 14'h1abc);
         prg.shift({26'h000_0000, `CMD_READ_WORD}, 6, 1'b1);
         check("read strobe", mem_read_out, 1'b1);
         check("read space", mem_space_out, `SPACE_EEPROM);
         prg.shift(32'h0000_0000, 14, 1'b0);
         check("read word", prg.rx[31:18], 14'h2d3c);
         check("data drive", prog_data_pin_oe_out, 1'b0);
         prg.shift({26'h000_0000, `CMD_INC_ADDR}, 6, 1'b1);
         check("next address", mem_addr_out, 16'hf006);
         write(`ADDR_CONFIG, 14'h0123, `SPACE_CONFIG);
         check("hv config word", mem_wdata_out, 14'h0123);
         prg.high_voltage_out = 1'b0;
         wait_for(2'b01, 2'b00);
         $display("hv test done");
      end
   endtask
   initial begin
      repeat (2) @(negedge ref_clk_in);
      resetn_in = 1'b1;
      repeat (6) @(negedge ref_clk_in);
      test_fuse;
      test_key;
      test_hv;
      test_done;
   end
endmodule
